/* design/uopif_pkg.sv */
// Constants shared by the USB pull, power and interrupt-flag front end.
// Assumes a 10 MHz system clock and 32-bit register words at byte offsets.
package uopif_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_OTG_CTRL = 8'h00;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h08;
  localparam logic [7:0] OFS_ERR_MASK = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;

  // Pull and bus-power control fields.
  localparam int B_DP_PULLUP = 7;
  localparam int B_DM_PULLUP = 6;
  localparam int B_DP_PULLDN = 5;
  localparam int B_DM_PULLDN = 4;
  localparam int B_BUS_POWER = 3;
  localparam int B_PULL_OVR = 2;
  localparam int B_BUS_CHARGE = 1;
  localparam int B_BUS_DISCH = 0;

  // Power control fields.
  localparam int B_ACT_PEND = 7;
  localparam int B_SLEEP_GUARD = 4;
  localparam int B_NOT_READY = 3;
  localparam int B_SUSPEND = 1;
  localparam int B_POWER_ON = 0;

  // Interrupt flag fields.
  localparam int B_STALL = 7;
  localparam int B_ATTACH = 6;
  localparam int B_RESUME = 5;
  localparam int B_IDLE = 4;
  localparam int B_TOKEN_DONE = 3;
  localparam int B_FRAME_START = 2;
  localparam int B_ERR_SUM = 1;
  localparam int B_RESET_DETACH = 0;

  // Mode register field.
  localparam int B_HOST_ROLE = 0;

  // Values after reset.
  localparam logic [7:0] RST_OTG_CTRL = 8'h00;
  localparam logic [7:0] RST_PWR_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ERR_MASK = 8'h00;

  // Writable masks: everything else reads zero or is hardware status.
  localparam logic [7:0] PWR_WR_MASK = 8'h13;
  localparam logic [7:0] FLAG_W1C_MASK = 8'hfd;

  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESUME_TIME_NS = 2500;
  localparam int ATTACH_QUIET_NS = 2500;
  localparam int IDLE_TIME_NS = 3000000;
  localparam int RESUME_CYCLES =
    (RESUME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ATTACH_CYCLES =
    (ATTACH_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYCLES_DEF =
    (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_CNT_W = 6;
  localparam int IDLE_CNT_W = 16;

  // Cycles the module stays not ready after being switched off.
  localparam int SETTLE_CYCLES = 8;
  localparam int SETTLE_CNT_W = 4;

endpackage : uopif_pkg

/* design/uopif_core.sv */
// USB pull-resistor, bus-power, power-state and interrupt-flag front end.
// Assumes all inputs are synchronous to clock; line state arrives decoded
// and the transfer engine reports its events as one-cycle pulses.
//
// Function
// - D+ and D- pull-up enables follow their control bits.
// - D+ and D- pull-down enables follow their control bits.
// - Bus-power drive bit requests power on VBUS.
// - Override bit selects software or hardware control of four pulls.
// - Bus-charge bit enables resistive VBUS charging.
// - Bus-discharge bit enables resistive VBUS discharging.
// - Activity-pending reads one from detected activity until notification.
// - Sleep guard blocks sleep during activity or pending notification.
// - Not-ready reads one while active or still settling after disable.
// - Suspend gates the USB clock and puts transceiver in low power.
// - Power bit zero holds pull, VBUS, clock and notify outputs inactive and releases pins.
// - Flags other than error summary set by hardware, cleared by writing one, zero leaves them.
// - Stall flag sets on stall handshake in either role.
// - Attach flag sets in host role after 2.5 us quiet non-SE0 bus.
// - Resume flag sets after K state held for 2.5 us.
// - Idle flag sets after idle state held for 3 ms.
// - Token-done flag sets when the current token finishes.
// - Clearing token-done advances the token status queue.
// - Frame-start flag sets on SOF received or host threshold.
// - Error summary reads one only for errors enabled by the mask.
// - Flag zero means bus reset in device role, detach in host role.
`timescale 1ns/1ps
module uopif_core #(
  parameter int IDLE_CYCLES = uopif_pkg::IDLE_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic lineJ,
  input wire logic lineK,
  input wire logic lineSe0,
  input wire logic busActivity,
  input wire logic [3:0] hwPullEn,
  input wire logic stallEvent,
  input wire logic tokenDoneEvent,
  input wire logic sofEvent,
  input wire logic busResetEvent,
  input wire logic detachEvent,
  input wire logic [7:0] errorStatus,
  output logic dplusPullupEn,
  output logic dminusPullupEn,
  output logic dplusPulldownEn,
  output logic dminusPulldownEn,
  output logic busPowerDrive,
  output logic busChargeEn,
  output logic busDischargeEn,
  output logic usbClockEnable,
  output logic xcvrLowPower,
  output logic pinsOwned,
  output logic hostRole,
  output logic sleepBlock,
  output logic activityNotify,
  output logic tokenQueueAdvance
);

  localparam logic [uopif_pkg::SHORT_CNT_W-1:0] RESUME_N =
    uopif_pkg::SHORT_CNT_W'(uopif_pkg::RESUME_CYCLES);
  localparam logic [uopif_pkg::SHORT_CNT_W-1:0] ATTACH_N =
    uopif_pkg::SHORT_CNT_W'(uopif_pkg::ATTACH_CYCLES);
  localparam logic [uopif_pkg::IDLE_CNT_W-1:0] IDLE_N =
    uopif_pkg::IDLE_CNT_W'(IDLE_CYCLES);
  localparam logic [uopif_pkg::SETTLE_CNT_W-1:0] SETTLE_N =
    uopif_pkg::SETTLE_CNT_W'(uopif_pkg::SETTLE_CYCLES);

  logic [7:0] otgCtrl;
  logic [7:0] errMask;
  logic sleepEntryGuard;
  logic suspendRequest;
  logic modulePowerOn;
  logic moduleNotReady;
  logic activityPending;
  logic [7:0] flags;
  logic [uopif_pkg::SETTLE_CNT_W-1:0] settleCount;
  logic [uopif_pkg::SHORT_CNT_W-1:0] kCount;
  logic [uopif_pkg::SHORT_CNT_W-1:0] quietCount;
  logic [uopif_pkg::IDLE_CNT_W-1:0] idleCount;
  logic attachArmed;
  logic [7:0] flagSet;
  logic [7:0] flagClr;
  logic [3:0] pullSel;

  // Decodes a write strobe aimed at one register offset.
  function automatic logic wrHit(input logic [7:0] ofs);
    wrHit = regWr && (regAddr == ofs);
  endfunction : wrHit

  // Saturating increment shared by the K and quiet line-state timers.
  function automatic logic [uopif_pkg::SHORT_CNT_W-1:0] satInc(
    input logic [uopif_pkg::SHORT_CNT_W-1:0] v,
    input logic [uopif_pkg::SHORT_CNT_W-1:0] lim
  );
    satInc = (v >= lim) ? v : v + 1'b1;
  endfunction : satInc

  // Software control registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      otgCtrl <= uopif_pkg::RST_OTG_CTRL;
      errMask <= uopif_pkg::RST_ERR_MASK;
      hostRole <= 1'b0;
      sleepEntryGuard <= 1'b0;
      suspendRequest <= 1'b0;
      modulePowerOn <= 1'b0;
    end else begin
      if (wrHit(uopif_pkg::OFS_OTG_CTRL)) begin
        otgCtrl <= regWrData[7:0];
      end
      if (wrHit(uopif_pkg::OFS_ERR_MASK)) begin
        errMask <= regWrData[7:0];
      end
      if (wrHit(uopif_pkg::OFS_MODE)) begin
        hostRole <= regWrData[uopif_pkg::B_HOST_ROLE];
      end
      if (wrHit(uopif_pkg::OFS_PWR_CTRL)) begin
        sleepEntryGuard <= regWrData[uopif_pkg::B_SLEEP_GUARD];
        suspendRequest <= regWrData[uopif_pkg::B_SUSPEND];
        modulePowerOn <= regWrData[uopif_pkg::B_POWER_ON];
      end
    end
  end

  // Pull and VBUS outputs; everything is released while switched off.
  always_comb begin
    pullSel = otgCtrl[uopif_pkg::B_PULL_OVR] ? otgCtrl[7:4] : hwPullEn;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dplusPullupEn <= 1'b0;
      dminusPullupEn <= 1'b0;
      dplusPulldownEn <= 1'b0;
      dminusPulldownEn <= 1'b0;
      busPowerDrive <= 1'b0;
      busChargeEn <= 1'b0;
      busDischargeEn <= 1'b0;
    end else begin
      dplusPullupEn <= modulePowerOn && pullSel[3];
      dminusPullupEn <= modulePowerOn && pullSel[2];
      dplusPulldownEn <= modulePowerOn && pullSel[1];
      dminusPulldownEn <= modulePowerOn && pullSel[0];
      busPowerDrive <= modulePowerOn
        && otgCtrl[uopif_pkg::B_BUS_POWER];
      busChargeEn <= modulePowerOn
        && otgCtrl[uopif_pkg::B_BUS_CHARGE];
      busDischargeEn <= modulePowerOn
        && otgCtrl[uopif_pkg::B_BUS_DISCH];
    end
  end

  // Power state outputs.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      usbClockEnable <= 1'b0;
      xcvrLowPower <= 1'b1;
      pinsOwned <= 1'b0;
    end else begin
      usbClockEnable <= modulePowerOn && !suspendRequest;
      xcvrLowPower <= !modulePowerOn || suspendRequest;
      pinsOwned <= modulePowerOn;
    end
  end

  // After the module is switched off it stays busy for a short settle time;
  // this only reports not-ready, and a write can re-enable it while the analog side is still down.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settleCount <= '0;
      moduleNotReady <= 1'b0;
    end else begin
      if (modulePowerOn) begin
        settleCount <= SETTLE_N;
      end else if (settleCount != '0) begin
        settleCount <= settleCount - 1'b1;
      end
      moduleNotReady <= modulePowerOn || (settleCount != '0);
    end
  end

  // Activity is pending for one cycle before its notification pulse.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      activityPending <= 1'b0;
      activityNotify <= 1'b0;
      sleepBlock <= 1'b0;
    end else begin
      activityPending <= modulePowerOn && busActivity;
      activityNotify <= activityPending;
      sleepBlock <= sleepEntryGuard
        && (busActivity || activityPending);
    end
  end

  // Line-state timers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kCount <= '0;
      quietCount <= '0;
      idleCount <= '0;
      attachArmed <= 1'b0;
    end else begin
      kCount <= lineK ? satInc(kCount, RESUME_N) : '0;
      if (busActivity || lineSe0) begin
        quietCount <= '0;
      end else begin
        quietCount <= satInc(quietCount, ATTACH_N);
      end
      if (!lineJ) begin
        idleCount <= '0;
      end else if (idleCount < IDLE_N) begin
        idleCount <= idleCount + 1'b1;
      end
      // Armed by a detached (SE0) bus so that one attach gives one flag.
      if (!hostRole) begin
        attachArmed <= 1'b0;
      end else if (lineSe0) begin
        attachArmed <= 1'b1;
      end else if (flagSet[uopif_pkg::B_ATTACH]) begin
        attachArmed <= 1'b0;
      end
    end
  end

  // Hardware set conditions; events are ignored while switched off.
  always_comb begin
    flagSet = '0;
    flagSet[uopif_pkg::B_STALL] = stallEvent;
    flagSet[uopif_pkg::B_ATTACH] = hostRole && attachArmed && !lineSe0
      && (quietCount == ATTACH_N - 1'b1) && !busActivity;
    flagSet[uopif_pkg::B_RESUME] = (kCount == RESUME_N - 1'b1) && lineK;
    flagSet[uopif_pkg::B_IDLE] =
      lineJ && (idleCount == IDLE_N - 1'b1);
    flagSet[uopif_pkg::B_TOKEN_DONE] = tokenDoneEvent;
    flagSet[uopif_pkg::B_FRAME_START] = sofEvent;
    flagSet[uopif_pkg::B_RESET_DETACH] =
      hostRole ? detachEvent : busResetEvent;
    flagSet = modulePowerOn ? flagSet : '0;
    flagClr = wrHit(uopif_pkg::OFS_IRQ_FLAGS)
      ? (regWrData[7:0] & uopif_pkg::FLAG_W1C_MASK) : '0;
  end

  // Sticky flags: a set in the clearing cycle wins over the clear.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags <= uopif_pkg::RST_FLAGS;
      tokenQueueAdvance <= 1'b0;
    end else begin
      flags <= (flags & ~flagClr) | flagSet;
      flags[uopif_pkg::B_ERR_SUM] <= |(errorStatus & errMask);
      tokenQueueAdvance <= flagClr[uopif_pkg::B_TOKEN_DONE]
        && flags[uopif_pkg::B_TOKEN_DONE];
    end
  end

  // Read port: data stands the cycle after the strobe only.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        uopif_pkg::OFS_OTG_CTRL: regRdData <= {24'h000000, otgCtrl};
        uopif_pkg::OFS_PWR_CTRL: regRdData <= {24'h000000,
          activityPending, 2'h0, sleepEntryGuard, moduleNotReady,
          1'h0, suspendRequest, modulePowerOn};
        uopif_pkg::OFS_IRQ_FLAGS: regRdData <= {24'h000000, flags};
        uopif_pkg::OFS_ERR_MASK: regRdData <= {24'h000000, errMask};
        uopif_pkg::OFS_MODE: regRdData <= {31'h00000000, hostRole};
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule : uopif_core

/* tb/uopif_assertions.sv */
// Checker for the USB pull, power and flag front end.
// Sees only the top module's ports; bound to every core at the foot.
`timescale 1ns/1ps
module uopif_checker #(
  parameter int IDLE_CYCLES = 40
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic busActivity,
  input wire logic dplusPullupEn,
  input wire logic dminusPullupEn,
  input wire logic dplusPulldownEn,
  input wire logic dminusPulldownEn,
  input wire logic usbClockEnable,
  input wire logic xcvrLowPower,
  input wire logic pinsOwned,
  input wire logic hostRole,
  input wire logic sleepBlock,
  input wire logic activityNotify,
  input wire logic tokenQueueAdvance
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_clock_gate: assert property (usbClockEnable != xcvrLowPower)
    else $error("Clock enable and low power disagree.");
  a_pins_released: assert property (!pinsOwned |->
    !(dplusPullupEn | dminusPullupEn | dplusPulldownEn | dminusPulldownEn))
    else $error("Pull enabled while pins are released.");
  a_notify_cause: assert property (activityNotify |->
    $past(busActivity, 2)) else $error("Notify without activity.");
  a_notify_prompt: assert property (busActivity ##1 pinsOwned |=>
    activityNotify) else $error("Activity not notified.");
  a_sleep_cause: assert property (sleepBlock |->
    $past(busActivity) || activityNotify) else $error("Needless block.");
  a_queue_cause: assert property (tokenQueueAdvance |-> $past(regWr &&
    regAddr == uopif_pkg::OFS_IRQ_FLAGS && regWrData[3]))
    else $error("Queue advanced without a token clear.");
  a_read_quiet: assert property (!$past(regRd) |->
    regRdData == 32'h0) else $error("Read data outside its cycle.");
  a_upper_zero: assert property (regRdData[31:8] == 24'h0)
    else $error("Upper read bits not zero.");
  a_unmapped_zero: assert property ($past(regRd) &&
    $past(regAddr) > 8'h10 |-> regRdData == 32'h0)
    else $error("Unmapped read not zero.");
  a_role_write: assert property ($changed(hostRole) |->
    $past(regWr && regAddr == uopif_pkg::OFS_MODE) ||
    $past(regWr && regAddr == uopif_pkg::OFS_MODE, 2))
    else $error("Role changed without a write.");

  c_notify: cover property (activityNotify);
  c_queue: cover property (tokenQueueAdvance);
  c_suspend: cover property (pinsOwned && xcvrLowPower);
endmodule : uopif_checker

bind uopif_core uopif_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk_u (
  .clock, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
  .busActivity, .dplusPullupEn, .dminusPullupEn, .dplusPulldownEn,
  .dminusPulldownEn, .usbClockEnable, .xcvrLowPower, .pinsOwned,
  .hostRole, .sleepBlock, .activityNotify, .tokenQueueAdvance
);

/* tb/uopif_far_side.sv */
// Far end of the cable: decoded line state and bus activity.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ps
module uopif_far_side (
  input wire logic clock,
  output logic lineJ,
  output logic lineK,
  output logic lineSe0,
  output logic busActivity
);
  // An empty cable rests in SE0 through the pull-downs, so no timer runs.
  initial begin
    {lineJ, lineK, lineSe0} = 3'b001;
    busActivity = 1'b0;
  end
  task automatic hold(logic [2:0] jks, int n);
    @(posedge clock);
    {lineJ, lineK, lineSe0} <= jks;
    repeat (n) @(posedge clock);
    {lineJ, lineK, lineSe0} <= 3'b001;
  endtask : hold
  task automatic blip;
    @(posedge clock);
    busActivity <= 1'b1;
    @(posedge clock);
    busActivity <= 1'b0;
  endtask : blip
endmodule : uopif_far_side

/* tb/uopif_core_tb.sv */
// Self-checking bench for the USB pull, power and flag front end.
// Assumes the checker is bound and the far side model drives the line.
`timescale 1ns/1ps
module uopif_core_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] hw = 4'h9;
  logic [4:0] ev = 5'h00;
  logic [7:0] es = 8'h00;
  logic [31:0] regRdData;
  logic lineJ, lineK, lineSe0, busActivity;
  logic dpu, dmu, dpd, dmd, pwr, chg, dis, uce, xlp, host, slp, ntf, adv;
  logic own;
  wire logic [31:0] pins = {25'h0, dpu, dmu, dpd, dmd, pwr, chg, dis};
  int numErrors = 0;
  int comparisons = 0;
  int advances = 0;

  always #50 clock = ~clock;
  always @(posedge clock) if (adv === 1'b1) advances++;

  uopif_far_side far_u (.clock(clock), .lineJ(lineJ), .lineK(lineK),
    .lineSe0(lineSe0), .busActivity(busActivity));
  uopif_core #(.IDLE_CYCLES(40)) dut_u (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .lineJ(lineJ), .lineK(lineK),
    .lineSe0(lineSe0), .busActivity(busActivity), .hwPullEn(hw),
    .stallEvent(ev[4]), .tokenDoneEvent(ev[3]), .sofEvent(ev[2]),
    .busResetEvent(ev[1]), .detachEvent(ev[0]), .errorStatus(es),
    .dplusPullupEn(dpu), .dminusPullupEn(dmu), .dplusPulldownEn(dpd),
    .dminusPulldownEn(dmd), .busPowerDrive(pwr), .busChargeEn(chg),
    .busDischargeEn(dis), .usbClockEnable(uce), .xcvrLowPower(xlp),
    .pinsOwned(own), .hostRole(host), .sleepBlock(slp),
    .activityNotify(ntf), .tokenQueueAdvance(adv));

  task ck(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      numErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    ck(regRdData, e);
  endtask : rd
  task pulse(logic [4:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 5'h00;
  endtask : pulse

  task t_reset;
    wr(8'h20, 32'hffffffff);
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
    ck({29'h0, own, uce, xlp}, 32'h1);
  endtask : t_reset
  task t_power;
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h09);
    ck({29'h0, own, uce, xlp}, 32'h6);
    wr(8'h04, 32'h3);
    rd(8'h04, 32'h0b);
    ck({29'h0, own, uce, xlp}, 32'h5);
    wr(8'h04, 32'h1);
  endtask : t_power
  task t_pulls;
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'hff);
    ck(pins, 32'h7f);
    wr(8'h00, 32'h0e);
    cyc(2);
    ck(pins, 32'h06);
    wr(8'h00, 32'hf1);
    cyc(2);
    ck(pins, 32'h49);
    @(posedge clock) hw <= 4'h6;
    cyc(2);
    ck(pins, 32'h31);
    wr(8'h00, 32'hff);
  endtask : t_pulls
  task automatic t_flags;
    logic [4:0] em[4] = '{5'h10, 5'h08, 5'h04, 5'h02};
    logic [31:0] fm[4] = '{32'h80, 32'h08, 32'h04, 32'h01};
    for (int i = 0; i < 4; i++) begin
      pulse(em[i]);
      rd(8'h08, fm[i]);
      wr(8'h08, 32'h0);
      rd(8'h08, fm[i]);
      wr(8'h08, fm[i]);
      rd(8'h08, 32'h0);
    end
    wr(8'h08, 32'h08);
    ck(32'(advances), 32'h1);
  endtask : t_flags
  task t_timers;
    wr(8'h04, 32'h3);
    far_u.hold(3'b010, 20);
    rd(8'h08, 32'h0);
    far_u.hold(3'b010, 30);
    rd(8'h08, 32'h20);
    wr(8'h08, 32'h20);
    wr(8'h04, 32'h1);
    far_u.hold(3'b100, 30);
    rd(8'h08, 32'h0);
    far_u.hold(3'b100, 50);
    rd(8'h08, 32'h10);
    wr(8'h08, 32'h10);
  endtask : t_timers
  task t_attach;
    wr(8'h10, 32'h1);
    cyc(2);
    far_u.hold(3'b100, 30);
    pulse(5'h01);
    rd(8'h08, 32'h41);
    ck(32'(host), 32'h1);
    wr(8'h08, 32'h41);
    wr(8'h10, 32'h0);
  endtask : t_attach
  task automatic t_activity;
    logic [1:0] seen;
    for (int g = 1; g >= 0; g--) begin
      wr(8'h04, g ? 32'h11 : 32'h01);
      seen = 2'b00;
      far_u.blip;
      for (int i = 0; i < 4; i++) begin
        cyc(1);
        seen = seen | {slp, ntf};
      end
      ck(32'(seen), g ? 32'h3 : 32'h1);
    end
  endtask : t_activity
  task t_error;
    wr(8'h0c, 32'h01);
    @(posedge clock) es <= 8'h02;
    rd(8'h08, 32'h0);
    @(posedge clock) es <= 8'h01;
    rd(8'h08, 32'h02);
    wr(8'h08, 32'h02);
    rd(8'h08, 32'h02);
    @(posedge clock) es <= 8'h00;
  endtask : t_error
  task t_off;
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h08);
    ck(pins, 32'h0);
    ck(32'(own), 32'h0);
    pulse(5'h10);
    cyc(12);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
  endtask : t_off

  // A reset in mid-run must drop every setting made before it.
  task t_rerun;
    wr(8'h04, 32'h13);
    @(posedge clock) rst_n <= 1'b0;
    cyc(2);
    ck({29'h0, own, uce, xlp}, 32'h1);
    ck(pins, 32'h0);
    @(posedge clock) rst_n <= 1'b1;
    for (int a = 0; a <= 16; a += 4) rd(8'(a), 32'h0);
  endtask : t_rerun

  task conclude;
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_power();
    t_pulls();
    t_flags();
    t_timers();
    t_attach();
    t_activity();
    t_error();
    t_off();
    t_rerun();
    conclude();
  end
endmodule : uopif_core_tb
